/* rtl/panel_pkg.sv */
package panel_pkg;
  // Clock and timing
  localparam longint CLK_PERIOD_NS = 5;
  // Keypad timeout counts in units of this length
  localparam longint KEY_UNIT_NS = 1000000;
  localparam longint KEY_UNIT_CYCLES = KEY_UNIT_NS / CLK_PERIOD_NS;
  // Backlight auto-off period
  localparam longint LIGHT_S = 30;
  localparam longint LIGHT_CYCLES = LIGHT_S * 1000000000 / CLK_PERIOD_NS;
  localparam int LIGHT_W = 34;
  // Strap settle time after reset release
  localparam logic [2:0] BOOT_SETTLE_CYC = 3'h4;
  // Bus geometry
  localparam int ADDR_W = 8;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_BOOT_FILE = 8'h04;
  localparam logic [7:0] ADDR_CONTRAST = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_FAULT = 8'h10;
  localparam logic [7:0] ADDR_KEY_WAIT = 8'h14;
  localparam logic [7:0] ADDR_WATCH = 8'h18;
  localparam logic [7:0] ADDR_LOW = 8'h1C;
  localparam logic [7:0] ADDR_HIGH = 8'h20;
  localparam logic [7:0] ADDR_KNOB0 = 8'h24;
  localparam logic [7:0] ADDR_KNOB1 = 8'h28;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h2C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h30;
  // Control register fields
  localparam int CTL_ADJ = 0;
  localparam int CTL_LIGHT = 1;
  localparam int CTL_PERIOD = 2;
  localparam int CTL_CONFIRM = 3;
  localparam int CTL_CANCEL = 4;
  // Status register fields
  localparam int ST_DONE = 0;
  localparam int ST_FAULT = 1;
  localparam int ST_ACTIVE = 2;
  localparam int ST_AT_BOOT = 3;
  localparam int ST_CUSTOM = 4;
  localparam int ST_UNSUP = 5;
  // Interrupt bits
  localparam int IRQ_N = 4;
  localparam int EV_DONE = 0;
  localparam int EV_FAULT = 1;
  localparam int EV_TIMEOUT = 2;
  localparam int EV_KEY = 3;
  // Reset values
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [15:0] BOOT_FILE_RST = 16'h0000;
  localparam logic [15:0] CONTRAST_RST = 16'h0019;
  localparam logic [15:0] LOW_RST = 16'h0000;
  localparam logic [15:0] HIGH_RST = 16'h00FA;
  // Contrast range
  localparam logic [15:0] CONTRAST_MIN = 16'h000F;
  localparam logic [15:0] CONTRAST_MAX = 16'h0023;
  // Fault codes
  localparam logic [15:0] FAULT_NONE = 16'h0000;
  localparam logic [15:0] FAULT_CORRUPT = 16'h0001;
  localparam logic [15:0] FAULT_RANGE = 16'h0002;
  // Image header type word for a bitmap
  localparam logic [15:0] IMG_TYPE_BMP = 16'h4D42;
  // Data file type codes
  localparam logic [2:0] FT_STATUS = 3'h0;
  localparam logic [2:0] FT_BIT = 3'h1;
  localparam logic [2:0] FT_INT = 3'h2;
  localparam logic [2:0] FT_LONG = 3'h3;
  localparam logic [2:0] FT_FLOAT = 3'h4;
  // Menu states
  typedef enum logic [2:0] {
    MENU_BOOT = 3'b001,
    MENU_STATUS = 3'b010,
    MENU_USER = 3'b100
  } menu_type;
endpackage

/* rtl/pin_sync3.sv */
`timescale 1ns/1ps
// Three-stage pin synchroniser with agreement filter
module pin_sync3 #(
  parameter int W = 1
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_pin,
  output logic [W-1:0] o_level
);
  generate
    for (genvar b = 0; b < W; b++)
    begin : g_bit
      logic [2:0] s_r; // Stage 0 feeds only stage 1
      // Shift chain per bit
      always_ff @(posedge i_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
          s_r <= 3'h0;
        else
          s_r <= {s_r[1:0], i_pin[b]};
      end
      // Accept a change only when stages 1 and 2 agree
      always_ff @(posedge i_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
          o_level[b] <= 1'b0;
        else if (s_r[1] == s_r[2])
          o_level[b] <= s_r[2];
      end
    end
  endgenerate
endmodule // pin_sync3

/* rtl/panel_ctrl.sv */
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// - Boot picture comes from selected file
// - Check header type and size first
// - Bad or short file shows default
// - Boot strap enters user display directly
// - Zero wait limit means no timeout
// - Key idle past limit leaves user display
// - No-input job done when shown
// - Input job done on confirm/cancel
// - Download checks knobs, sets fault flag
// - Fault code 0, 1 or 2
// - Unsupported watched file type flagged
// - Download clamps knobs to nearer bound
// - Confirm latch sticks until software clears
// - Active flag while in user display
// - Backlight 30 s timer or always on
module panel_ctrl
  import panel_pkg::*;
#(
  parameter int KEY_UNIT_CYC = int'(KEY_UNIT_CYCLES),
  parameter longint LIGHT_CYC = LIGHT_CYCLES
)
(
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_irq,
  input wire logic i_key_confirm,
  input wire logic i_key_cancel,
  input wire logic i_key_other,
  input wire logic i_user_screen_at_boot,
  input wire logic [15:0] i_hdr_type,
  input wire logic [15:0] i_hdr_size,
  input wire logic [15:0] i_file_room,
  input wire logic i_menu_user,
  input wire logic i_menu_back,
  input wire logic i_instr_start,
  input wire logic i_instr_with_input,
  input wire logic i_instr_shown,
  input wire logic i_download,
  input wire logic [15:0] i_new_low,
  input wire logic [15:0] i_new_high,
  input wire logic [15:0] i_new_key_wait,
  input wire logic [15:0] i_new_watch_file,
  input wire logic i_knob_move,
  input wire logic i_knob_sel,
  input wire logic [15:0] i_knob_value,
  input wire logic i_knob_corrupt,
  input wire logic [2:0] i_watched_type,
  output logic [15:0] o_boot_file,
  output logic o_custom_image,
  output logic o_user_screen_active,
  output logic o_done,
  output logic o_type_unsupported,
  output logic o_backlight,
  output logic [15:0] o_contrast,
  output logic o_immediate_adjust
);
  localparam int UW = $clog2(KEY_UNIT_CYC + 1);

  // Refuse counts the counters cannot hold
  if (KEY_UNIT_CYC < 1 || LIGHT_CYC < 1 || LIGHT_CYC >= (64'd1 << LIGHT_W))
  begin : g_bad_param
    $error("panel_ctrl: timing parameter out of range");
  end

  logic [1:0] rst_sync_r; // Reset release chain
  logic rst_n; // Synchronised reset
  logic [3:0] key_lvl; // Filtered pin levels
  logic [2:0] key_prev_r; // Previous key levels
  logic press_ok, press_esc, press_any; // Key press pulses
  menu_type menu_r; // Menu state
  logic [2:0] boot_cnt_r; // Strap settle counter
  logic at_boot_r; // Strap caught after settle time
  logic [4:0] ctrl_r; // Control bits
  logic [15:0] low_r, high_r, key_wait_r, watch_r; // Download words
  logic [15:0] knob_r [2]; // Knob positions
  logic [15:0] fault_code_r; // Fault code
  logic fault_flag_r; // Range fault flag
  logic with_input_r; // Current job waits for keys
  logic [IRQ_N-1:0] irq_stat_r, irq_mask_r, ev; // Interrupts
  logic [UW-1:0] unit_cnt_r; // Timeout unit prescaler
  logic [15:0] wait_cnt_r; // Elapsed idle units
  logic unit_tick, timeout; // Timeout events
  logic [LIGHT_W-1:0] light_cnt_r; // Backlight timer
  logic [1:0] viol; // Knob outside new bounds
  logic [15:0] fixed [2]; // Knob clamped to new bounds
  logic pready_r, acc, wr, rd; // Bus phases
  logic hit; // Address decodes
  logic [31:0] rd_mux; // Read data select

  // Two-flop reset release
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  // Pin filtering for keys and the boot strap
  pin_sync3 #(.W(4)) u_sync (
    .i_clk(i_mclk),
    .i_rst_n(rst_n),
    .i_pin({i_user_screen_at_boot, i_key_other, i_key_cancel,
            i_key_confirm}),
    .o_level(key_lvl)
  );

  // Press edges from filtered levels
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
      key_prev_r <= 3'h0;
    else
      key_prev_r <= key_lvl[2:0];
  end
  assign press_ok = key_lvl[0] && !key_prev_r[0];
  assign press_esc = key_lvl[1] && !key_prev_r[1];
  assign press_any = |(key_lvl[2:0] & ~key_prev_r);

  // Bus phases: no wait state, answer on first access edge
  assign acc = i_psel && i_penable && pready_r;
  assign wr = acc && i_pwrite;
  assign rd = acc && !i_pwrite;

  // Read select and decode
  always_comb
  begin
    rd_mux = 32'h0;
    hit = 1'b1;
    case (i_paddr)
      ADDR_CTRL: rd_mux[4:0] = ctrl_r;
      ADDR_BOOT_FILE: rd_mux[15:0] = o_boot_file;
      ADDR_CONTRAST: rd_mux[15:0] = o_contrast;
      ADDR_STATUS:
      begin
        rd_mux[ST_DONE] = o_done;
        rd_mux[ST_FAULT] = fault_flag_r;
        rd_mux[ST_ACTIVE] = o_user_screen_active;
        rd_mux[ST_AT_BOOT] = at_boot_r;
        rd_mux[ST_CUSTOM] = o_custom_image;
        rd_mux[ST_UNSUP] = o_type_unsupported;
      end
      ADDR_FAULT: rd_mux[15:0] = fault_code_r;
      ADDR_KEY_WAIT: rd_mux[15:0] = key_wait_r;
      ADDR_WATCH: rd_mux[15:0] = watch_r;
      ADDR_LOW: rd_mux[15:0] = low_r;
      ADDR_HIGH: rd_mux[15:0] = high_r;
      ADDR_KNOB0: rd_mux[15:0] = knob_r[0];
      ADDR_KNOB1: rd_mux[15:0] = knob_r[1];
      ADDR_IRQ_STAT: rd_mux[IRQ_N-1:0] = irq_stat_r;
      ADDR_IRQ_MASK: rd_mux[IRQ_N-1:0] = irq_mask_r;
      default: hit = 1'b0;
    endcase
  end

  // Answer is prepared in the setup cycle and held through access
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_r <= 1'b0;
      o_prdata <= 32'h0;
      o_pslverr <= 1'b0;
    end
    else if (i_psel && !i_penable)
    begin
      pready_r <= 1'b1;
      o_prdata <= i_pwrite ? 32'h0 : rd_mux;
      o_pslverr <= !hit;
    end
    else
    begin
      pready_r <= 1'b0;
      o_pslverr <= 1'b0;
    end
  end
  assign o_pready = pready_r;

  // Menu sequencing: boot, status screen, user display
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      menu_r <= MENU_BOOT;
      boot_cnt_r <= 3'h0;
      at_boot_r <= 1'b0;
      o_custom_image <= 1'b0;
    end
    else
    begin
      case (menu_r)
        MENU_BOOT:
        begin
          boot_cnt_r <= boot_cnt_r + 3'h1;
          if (boot_cnt_r == BOOT_SETTLE_CYC)
          begin
            at_boot_r <= key_lvl[3];
            // Custom picture only with right type and enough room
            o_custom_image <= (i_hdr_type == IMG_TYPE_BMP) &&
              (i_hdr_size != 16'h0) && (i_hdr_size <= i_file_room);
            menu_r <= key_lvl[3] ? MENU_USER : MENU_STATUS;
          end
        end
        MENU_STATUS:
          if (i_menu_user)
            menu_r <= MENU_USER;
        MENU_USER:
          if (i_menu_back || timeout)
            menu_r <= MENU_STATUS;
        default:
          menu_r <= MENU_STATUS;
      endcase
    end
  end

  // Active flag tracks user display
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
      o_user_screen_active <= 1'b0;
    else
      o_user_screen_active <= (menu_r == MENU_USER);
  end

  // Idle key timeout, in units of KEY_UNIT_CYC cycles
  assign unit_tick = (unit_cnt_r == UW'(KEY_UNIT_CYC - 1));
  assign timeout = (menu_r == MENU_USER) && (key_wait_r != 16'h0) &&
    unit_tick && (wait_cnt_r >= key_wait_r - 16'h1);
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      unit_cnt_r <= '0;
      wait_cnt_r <= 16'h0;
    end
    else if (menu_r != MENU_USER || press_any)
    begin
      unit_cnt_r <= '0;
      wait_cnt_r <= 16'h0;
    end
    else if (unit_tick)
    begin
      unit_cnt_r <= '0;
      // Saturate so a long idle count holds at FFFF instead of wrapping to zero
      if (wait_cnt_r != 16'hFFFF)
        wait_cnt_r <= wait_cnt_r + 16'h1;
    end
    else
      unit_cnt_r <= unit_cnt_r + UW'(1);
  end

  // Job done flag; a new job clears it, completion sets it
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_done <= 1'b0;
      with_input_r <= 1'b0;
    end
    else
    begin
      if (i_instr_start)
      begin
        o_done <= 1'b0;
        with_input_r <= i_instr_with_input;
      end
      if (i_instr_shown && !with_input_r)
        o_done <= 1'b1;
      if (with_input_r && (menu_r == MENU_USER) && (press_ok || press_esc))
      begin
        o_done <= 1'b1;
        with_input_r <= 1'b0;
      end
    end
  end

  // Control bits; key presses win over a software clear
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_r <= CTRL_RST;
    else
    begin
      if (wr && i_paddr == ADDR_CTRL)
        ctrl_r <= i_pwdata[4:0];
      if (menu_r == MENU_USER && press_ok)
        ctrl_r[CTL_CONFIRM] <= 1'b1;
      if (menu_r == MENU_USER && press_esc)
        ctrl_r[CTL_CANCEL] <= 1'b1;
    end
  end

  // Boot file and contrast, contrast clamped to its range
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_boot_file <= BOOT_FILE_RST;
      o_contrast <= CONTRAST_RST;
    end
    else if (wr && i_paddr == ADDR_BOOT_FILE)
      o_boot_file <= i_pwdata[15:0];
    else if (wr && i_paddr == ADDR_CONTRAST)
    begin
      if (i_pwdata[15:0] < CONTRAST_MIN)
        o_contrast <= CONTRAST_MIN;
      else if (i_pwdata[15:0] > CONTRAST_MAX)
        o_contrast <= CONTRAST_MAX;
      else
        o_contrast <= i_pwdata[15:0];
    end
  end

  // Per-knob check against the incoming bounds
  generate
    for (genvar k = 0; k < 2; k++)
    begin : g_knob
      logic below, above; // Side of the violation
      assign below = knob_r[k] < i_new_low;
      assign above = knob_r[k] > i_new_high;
      assign viol[k] = below || above;
      // Crossed bounds: both true, take the closer one
      always_comb
      begin
        fixed[k] = knob_r[k];
        if (below && above)
          fixed[k] = ((i_new_low - knob_r[k]) <= (knob_r[k] - i_new_high))
            ? i_new_low : i_new_high;
        else if (below)
          fixed[k] = i_new_low;
        else if (above)
          fixed[k] = i_new_high;
      end
    end
  endgenerate

  // Download: load words, clamp knobs, update fault state
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      low_r <= LOW_RST;
      high_r <= HIGH_RST;
      key_wait_r <= 16'h0;
      watch_r <= 16'h0;
      knob_r[0] <= LOW_RST;
      knob_r[1] <= LOW_RST;
      fault_flag_r <= 1'b0;
      fault_code_r <= FAULT_NONE;
    end
    else if (i_download)
    begin
      // Single pulse completes the whole check
      low_r <= i_new_low;
      high_r <= i_new_high;
      key_wait_r <= i_new_key_wait;
      watch_r <= i_new_watch_file;
      knob_r[0] <= fixed[0];
      knob_r[1] <= fixed[1];
      fault_flag_r <= |viol;
      fault_code_r <= (|viol) ? FAULT_RANGE : FAULT_NONE;
    end
    else
    begin
      if (i_knob_corrupt)
        fault_code_r <= FAULT_CORRUPT;
      // Live knob moves stay inside current bounds
      if (i_knob_move)
      begin
        if (i_knob_value < low_r)
          knob_r[i_knob_sel] <= low_r;
        else if (i_knob_value > high_r)
          knob_r[i_knob_sel] <= high_r;
        else
          knob_r[i_knob_sel] <= i_knob_value;
      end
    end
  end

  // Watched file type check
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
      o_type_unsupported <= 1'b0;
    else
      o_type_unsupported <= !(i_watched_type inside
        {FT_STATUS, FT_BIT, FT_INT, FT_LONG, FT_FLOAT});
  end

  // Backlight timer restarts on any key press
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
      light_cnt_r <= LIGHT_W'(LIGHT_CYC);
    else if (press_any)
      light_cnt_r <= LIGHT_W'(LIGHT_CYC);
    else if (light_cnt_r != '0)
      light_cnt_r <= light_cnt_r - LIGHT_W'(1);
  end

  // Backlight output
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
      o_backlight <= 1'b0;
    else
      o_backlight <= ctrl_r[CTL_LIGHT] &&
        (ctrl_r[CTL_PERIOD] || light_cnt_r != '0);
  end

  // Event sources
  always_comb
  begin
    ev = '0;
    ev[EV_DONE] = (i_instr_shown && !with_input_r) ||
      (with_input_r && menu_r == MENU_USER && (press_ok || press_esc));
    ev[EV_FAULT] = i_download && (|viol);
    ev[EV_TIMEOUT] = timeout;
    ev[EV_KEY] = (menu_r == MENU_USER) && (press_ok || press_esc);
  end

  // Sticky status cleared by read; only bits seen are cleared
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
    end
    else
    begin
      if (rd && i_paddr == ADDR_IRQ_STAT)
        irq_stat_r <= (irq_stat_r & ~o_prdata[IRQ_N-1:0]) | ev;
      else
        irq_stat_r <= irq_stat_r | ev;
      if (wr && i_paddr == ADDR_IRQ_MASK)
        irq_mask_r <= i_pwdata[IRQ_N-1:0];
    end
  end

  // Interrupt line
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
      o_irq <= 1'b0;
    else
      o_irq <= |(irq_stat_r & irq_mask_r);
  end
  assign o_immediate_adjust = ctrl_r[CTL_ADJ];
endmodule // panel_ctrl

/* tb/panel_ctrl_sva.sv */
`timescale 1ns/1ps
// Port-level checks of the panel control file
module panel_ctrl_sva
  import panel_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic i_instr_start,
  input wire logic i_instr_with_input,
  input wire logic i_instr_shown,
  input wire logic i_menu_back,
  input wire logic [2:0] i_watched_type,
  input wire logic [15:0] o_boot_file,
  input wire logic o_user_screen_active,
  input wire logic o_done,
  input wire logic o_type_unsupported,
  input wire logic [15:0] o_contrast,
  input wire logic o_immediate_adjust
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  // Input mode of the job in flight
  logic wi_r;
  // Write taking effect at this edge
  logic wr_acc;
  assign wr_acc = i_psel && i_penable && o_pready && i_pwrite;
  // Track mode only at job start; shown pulses do not change it
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
      wi_r <= 1'h0;
    else if (i_instr_start)
      wi_r <= i_instr_with_input;
  end
  a_ready_setup: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  a_err_map: assert property (
    i_psel && !i_penable && i_paddr > ADDR_IRQ_MASK |=> o_pslverr)
    else $error("unmapped access not refused");
  a_err_data: assert property (o_pslverr |-> o_pready && o_prdata == 0)
    else $error("refused access with data");
  a_boot_file: assert property (
    wr_acc && i_paddr == ADDR_BOOT_FILE
    |=> o_boot_file == $past(i_pwdata[15:0]))
    else $error("boot file not written");
  a_adjust_bit: assert property (wr_acc && i_paddr == ADDR_CTRL
    |=> o_immediate_adjust == $past(i_pwdata[CTL_ADJ]))
    else $error("adjust bit not written");
  a_contrast_in: assert property (
    o_contrast >= CONTRAST_MIN && o_contrast <= CONTRAST_MAX)
    else $error("contrast out of range");
  a_done_shown: assert property (
    !wi_r && i_instr_shown && !i_instr_start |-> ##[1:2] o_done)
    else $error("job done missing");
  a_done_held: assert property (
    wi_r && i_instr_shown && !i_instr_start && !o_done |=> !o_done)
    else $error("input job done without key");
  a_unsup_set: assert property (
    (i_watched_type > FT_FLOAT) [*3] |=> o_type_unsupported)
    else $error("unsupported type not flagged");
  a_unsup_clr: assert property (
    (i_watched_type <= FT_FLOAT) [*3] |=> !o_type_unsupported)
    else $error("supported type flagged");
  a_leave_user: assert property (
    i_menu_back |-> ##[1:2] !o_user_screen_active)
    else $error("still active after leaving");
  c_refused: cover property (o_pslverr);
  c_input_done: cover property (o_done && wi_r);
  c_unsup: cover property (o_type_unsupported);
endmodule // panel_ctrl_sva

/* tb/panel_keypad.sv */
`timescale 1ns/1ps
// Operator keypad: holds one key, then lets go
module panel_keypad
(
  input wire logic i_clk,
  output logic o_confirm,
  output logic o_cancel,
  output logic o_other
);
  // Released keys read low
  initial
  begin
    o_confirm = 1'h0;
    o_cancel = 1'h0;
    o_other = 1'h0;
  end
  // Held 8 cycles so the pin filter sees it
  task automatic press(input int k);
    @(posedge i_clk);
    o_confirm <= (k == 0);
    o_cancel <= (k == 1);
    o_other <= (k == 2);
    repeat (8) @(posedge i_clk);
    o_confirm <= 1'h0;
    o_cancel <= 1'h0;
    o_other <= 1'h0;
  endtask
endmodule // panel_keypad

/* tb/panel_ctrl_test.sv */
`timescale 1ns/1ps
// Register and event tests of the panel control file
module panel_ctrl_test
  import panel_pkg::*;
();
`define CHK(nm, ex, got) \
  begin \
    compares++; \
    if ((got) !== (ex)) \
    begin \
      n_mismatch++; \
      $display("MISMATCH %s exp %0h got %0h", nm, ex, got); \
    end \
  end
  logic i_mclk, i_resetn, i_psel, i_penable, i_pwrite;
  logic [7:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, q;
  logic o_pready, o_pslverr, o_irq, e;
  logic i_key_confirm, i_key_cancel, i_key_other, i_user_screen_at_boot;
  logic [15:0] i_hdr_type, i_hdr_size, i_file_room, i_knob_value;
  logic i_menu_user, i_menu_back, i_instr_start, i_instr_with_input;
  logic i_instr_shown, i_download, i_knob_move, i_knob_sel, i_knob_corrupt;
  logic [15:0] i_new_low, i_new_high, i_new_key_wait, i_new_watch_file;
  logic [2:0] i_watched_type;
  logic [15:0] o_boot_file, o_contrast;
  logic o_custom_image, o_user_screen_active, o_done;
  logic o_type_unsupported, o_backlight, o_immediate_adjust;
  int n_mismatch = 0;
  int compares = 0;
  // Short counts keep timer tests brief
  panel_ctrl #(.KEY_UNIT_CYC(4), .LIGHT_CYC(50)) i_dut (.*);
  panel_keypad kp (.i_clk(i_mclk), .o_confirm(i_key_confirm),
    .o_cancel(i_key_cancel), .o_other(i_key_other));
  always #2.5 i_mclk = ~i_mclk;
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Hang guard
  initial
  begin
    #200000;
    n_mismatch++;
    give_verdict();
  end
  // One APB transfer; pready sampled at each rising edge
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] rq, output logic re);
    int n;
    n = 0;
    @(posedge i_mclk);
    i_psel <= 1'h1;
    i_penable <= 1'h0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_mclk);
    i_penable <= 1'h1;
    @(posedge i_mclk);
    while (o_pready !== 1'h1 && n < 16)
    begin
      n++;
      @(posedge i_mclk);
    end
    if (n == 16)
    begin
      n_mismatch++;
      give_verdict();
    end
    rq = o_prdata;
    re = o_pslverr;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
    input string nm);
    apb(1'h0, a, 32'h0, q, e);
    `CHK(nm, x, q)
  endtask
  task automatic fin(input string s);
    $display("test %s done", s);
  endtask
  task automatic do_reset(input logic strap, input logic [15:0] ty);
    i_resetn <= 1'h0;
    i_user_screen_at_boot <= strap;
    i_hdr_type <= ty;
    repeat (16) @(posedge i_mclk);
    i_resetn <= 1'h1;
    repeat (12) @(posedge i_mclk);
  endtask
  // Enter (1) or leave (0) the user display
  task automatic menu(input logic u);
    @(posedge i_mclk);
    i_menu_user <= u;
    i_menu_back <= !u;
    @(posedge i_mclk);
    i_menu_user <= 1'h0;
    i_menu_back <= 1'h0;
  endtask
  task automatic job(input logic wi);
    @(posedge i_mclk);
    i_instr_with_input <= wi;
    i_instr_start <= 1'h1;
    @(posedge i_mclk);
    i_instr_start <= 1'h0;
    i_instr_shown <= 1'h1;
    @(posedge i_mclk);
    i_instr_shown <= 1'h0;
    repeat (3) @(posedge i_mclk);
  endtask
  task automatic dl(input logic [15:0] lo, hi, kw);
    @(posedge i_mclk);
    i_new_low <= lo;
    i_new_high <= hi;
    i_new_key_wait <= kw;
    i_new_watch_file <= 16'h0009;
    i_download <= 1'h1;
    @(posedge i_mclk);
    i_download <= 1'h0;
    repeat (2) @(posedge i_mclk);
  endtask
  task automatic knob(input logic s, input logic [15:0] v);
    @(posedge i_mclk);
    i_knob_sel <= s;
    i_knob_value <= v;
    i_knob_move <= 1'h1;
    @(posedge i_mclk);
    i_knob_move <= 1'h0;
  endtask
  initial
  begin
    {i_mclk, i_resetn, i_psel, i_penable, i_pwrite, i_paddr} = 0;
    {i_pwdata, i_user_screen_at_boot, i_hdr_type, i_knob_value} = 0;
    {i_menu_user, i_menu_back, i_instr_start, i_instr_with_input} = 0;
    {i_instr_shown, i_download, i_knob_move, i_knob_sel} = 0;
    {i_new_low, i_new_high, i_new_key_wait, i_new_watch_file} = 0;
    {i_knob_corrupt, i_watched_type} = 0;
    i_hdr_size = 16'h0010;
    i_file_room = 16'h0100;
    // Bad header, strap low: default image, status screen
    do_reset(1'h0, 16'h0000);
    rd(ADDR_CTRL, 32'h0, "ctrl");
    rd(ADDR_CONTRAST, 32'h19, "contrast");
    rd(ADDR_HIGH, 32'hFA, "high");
    rd(ADDR_STATUS, 32'h0, "status");
    apb(1'h0, 8'h34, 32'h0, q, e);
    `CHK("unmapped err", 1'h1, e)
    `CHK("unmapped data", 32'h0, q)
    `CHK("default image", 1'h0, o_custom_image)
    wr(ADDR_BOOT_FILE, 32'h0007);
    rd(ADDR_BOOT_FILE, 32'h7, "boot file");
    `CHK("boot file out", 16'h0007, o_boot_file)
    wr(ADDR_CTRL, 32'h1);
    fin("registers");
    // Download clamps knobs and reports faults
    wr(ADDR_IRQ_MASK, 32'h2);
    dl(16'h0000, 16'h03FF, 16'h0000);
    knob(1'h0, 16'h03E8);
    knob(1'h1, 16'h0005);
    dl(16'h0000, 16'h00FA, 16'h0000);
    rd(ADDR_KNOB0, 32'hFA, "knob0 clamp");
    rd(ADDR_KNOB1, 32'h5, "knob1 kept");
    rd(ADDR_STATUS, 32'h2, "fault flag");
    rd(ADDR_FAULT, 32'h2, "code range");
    rd(ADDR_WATCH, 32'h9, "watch file");
    `CHK("irq raised", 1'h1, o_irq)
    rd(ADDR_IRQ_STAT, 32'h2, "irq stat");
    repeat (2) @(posedge i_mclk);
    `CHK("irq cleared", 1'h0, o_irq)
    wr(ADDR_IRQ_MASK, 32'h0);
    dl(16'h0010, 16'h0100, 16'h0000);
    rd(ADDR_KNOB1, 32'h10, "knob1 clamp");
    `CHK("irq masked", 1'h0, o_irq)
    dl(16'h0000, 16'h03FF, 16'h0000);
    rd(ADDR_STATUS, 32'h0, "fault clear");
    rd(ADDR_FAULT, 32'h0, "code none");
    @(posedge i_mclk);
    i_knob_corrupt <= 1'h1;
    @(posedge i_mclk);
    i_knob_corrupt <= 1'h0;
    rd(ADDR_FAULT, 32'h1, "code corrupt");
    fin("download");
    // Jobs, key latches and timeout in user display
    menu(1'h0);
    menu(1'h1);
    job(1'h0);
    `CHK("done shown", 1'h1, o_done)
    job(1'h1);
    `CHK("done waits", 1'h0, o_done)
    kp.press(0);
    repeat (6) @(posedge i_mclk);
    `CHK("done key", 1'h1, o_done)
    rd(ADDR_CTRL, 32'h9, "confirm latch");
    wr(ADDR_CTRL, 32'h1);
    rd(ADDR_CTRL, 32'h1, "latch cleared");
    kp.press(1);
    rd(ADDR_CTRL, 32'h11, "cancel latch");
    wr(ADDR_CTRL, 32'h1);
    repeat (40) @(posedge i_mclk);
    `CHK("no timeout", 1'h1, o_user_screen_active)
    dl(16'h0000, 16'h03FF, 16'h0002);
    repeat (30) @(posedge i_mclk);
    `CHK("timed out", 1'h0, o_user_screen_active)
    fin("keys");
    // Every watched file type code
    for (int t = 0; t < 8; t++)
    begin
      @(posedge i_mclk);
      i_watched_type <= 3'(t);
      repeat (4) @(posedge i_mclk);
      `CHK("unsupported", 1'(t > 4), o_type_unsupported)
    end
    i_watched_type <= 3'h0;
    fin("types");
    // Backlight held on, then timed off after a key
    wr(ADDR_CTRL, 32'h6);
    repeat (60) @(posedge i_mclk);
    `CHK("light held", 1'h1, o_backlight)
    wr(ADDR_CTRL, 32'h2);
    kp.press(2);
    `CHK("light on", 1'h1, o_backlight)
    repeat (60) @(posedge i_mclk);
    `CHK("light off", 1'h0, o_backlight)
    fin("backlight");
    // Good header, strap high: custom image, user display
    do_reset(1'h1, IMG_TYPE_BMP);
    `CHK("custom image", 1'h1, o_custom_image)
    `CHK("user at boot", 1'h1, o_user_screen_active)
    rd(ADDR_STATUS, 32'h1C, "boot status");
    fin("boot");
    give_verdict();
  end
endmodule // panel_ctrl_test
bind panel_ctrl panel_ctrl_sva i_sva (.i_mclk, .i_resetn, .i_psel,
  .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
  .o_pslverr, .i_instr_start, .i_instr_with_input, .i_instr_shown,
  .i_menu_back, .i_watched_type, .o_boot_file, .o_user_screen_active,
  .o_done, .o_type_unsupported, .o_contrast, .o_immediate_adjust);
